// ---- ubf_uart_map.svh ----
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef UBF_UART_MAP_SVH
`define UBF_UART_MAP_SVH

`define UBF_OFF_BUF 3'h0
`define UBF_OFF_IER 3'h1
`define UBF_OFF_IIR 3'h2
`define UBF_OFF_LCR 3'h3
`define UBF_OFF_MCR 3'h4
`define UBF_OFF_LSR 3'h5
`define UBF_OFF_MSR 3'h6
`define UBF_OFF_SCR 3'h7

`define UBF_LCR_PEN 3
`define UBF_LCR_EPS 4
`define UBF_LCR_STICK 5
`define UBF_LCR_BREAK 6
`define UBF_LCR_DIVISOR_LATCH_ACCESS 7

`define UBF_IER_RXDATA 0
`define UBF_IER_TX_HOLDING_EMPTY 1
`define UBF_IER_LINE 2
`define UBF_IER_PROG_TX_THRESHOLD_IRQ_EN 7

`define UBF_FCR_FIFO_ENABLE_BIT 0
`define UBF_FCR_RXRST 1
`define UBF_FCR_TXRST 2

`define UBF_IID_NONE 4'h1
`define UBF_IID_TX_HOLDING_EMPTY 4'h2
`define UBF_IID_RXDATA 4'h4
`define UBF_IID_LINE 4'h6
`define UBF_IID_TIMEOUT 4'hC

`define UBF_RESET_BYTE 8'h00
`define UBF_RESET_DIV 8'h00
`define UBF_FIFO_DEPTH 5'h10
`define UBF_OVERSAMPLE 5'h10
`define UBF_MID_SAMPLE 6'h07
`define UBF_BIT_LAST 6'h0F
`define UBF_STOP_ONE 6'h10
`define UBF_STOP_HALF 6'h18
`define UBF_STOP_TWO 6'h20
`define UBF_TIMEOUT_TICKS 10'h280

`endif

// ---- ubf_pkg.sv ----
// Types shared by the serial port files
package ubf_pkg;
   typedef logic [7:0] ubf_byte_t;
   typedef logic [2:0] ubf_addr_t;
   typedef enum logic [2:0] {
      UBF_IDLE = 3'b000,
      UBF_START = 3'b001,
      UBF_DATA = 3'b011,
      UBF_PARITY = 3'b010,
      UBF_STOP = 3'b110
   } ubf_state_t;
endpackage

// ---- ubf_fifo_mem.sv ----
// Small FIFO storage with registered, write-first read port
`timescale 1ns/1ps
module ubf_fifo_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Bypass so a word written into the head slot is seen at once
   always_ff @(posedge clk_sys) begin
      if (wrEn && wrAddr == rdAddr) begin
         rdData <= wrData;
      end else begin
         rdData <= mem[rdAddr];
      end
   end
endmodule

// ---- ubf_uart.sv ----
// 16550-style serial port: registers, baud generator, FIFOs, framing and interrupt
`timescale 1ns/1ps
`include "ubf_uart_map.svh"
// How it works
// - Line control sets bits, parity, stop length
// - Bit rate is clock over sixteen times divisor
// - Divisor bytes live at buffer and enable
// - Latch-access bit switches those locations to divisor
// - Zero divisor stops all serial activity except the break bit, which still forces the transmit pin low
// - Divisor resets to zero
// - FIFOs off at reset; sixteen deep when on
// - No request-to-send or clear-to-send pins
// - Four prioritized interrupt sources; timeout shares the data enable bit
// - Character timeout only in FIFO mode
// - Threshold mode: interrupt at or below level
// - Identification read, FIFO control write, same location
// - Trigger code 10 gives quarter-full threshold
// - Enable bit seven selects threshold mode when FIFOs are on
// - Behaves as a 16550 register model
module ubf_uart (
   input wire logic clk_sys,
   input wire logic reset,
   input wire ubf_pkg::ubf_addr_t regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire ubf_pkg::ubf_byte_t regWrData,
   output ubf_pkg::ubf_byte_t regRdData,
   input wire logic serialRxPin,
   output logic serialTxPin,
   output logic irqOut
);
   import ubf_pkg::*;

   // Receive trigger levels 1, 4, 8, 14
   function automatic logic [4:0] rxTrigLevel(input logic [1:0] code);
      case (code)
         2'h0: rxTrigLevel = 5'h01;
         2'h1: rxTrigLevel = 5'h04;
         2'h2: rxTrigLevel = 5'h08;
         default: rxTrigLevel = 5'h0E;
      endcase
   endfunction

   // Transmit thresholds: empty, two, quarter, half
   function automatic logic [4:0] txThreshold(input logic [1:0] code);
      case (code)
         2'h0: txThreshold = 5'h00;
         2'h1: txThreshold = 5'h02;
         2'h2: txThreshold = 5'h04;
         default: txThreshold = 5'h08;
      endcase
   endfunction

   // Line parity of the first n data bits, n = 5..8
   function automatic logic parityOf(input ubf_byte_t data, input logic [1:0] wls);
      ubf_byte_t mask;
      mask = 8'hFF >> (2'h3 - wls);
      parityOf = ^(data & mask);
   endfunction

   ubf_byte_t lcrReg, ierReg, mcrReg, scrReg, dllReg, dlmReg;
   logic fifoEnReg;
   logic [1:0] rxTrigReg, tetReg;
   logic [15:0] baudCntReg;
   logic tickReg;

   wire divisor_latch_access = lcrReg[`UBF_LCR_DIVISOR_LATCH_ACCESS];
   wire [15:0] divisor = {dlmReg, dllReg};
   wire baudRun = divisor != 16'h0000;
   wire [1:0] wls = lcrReg[1:0];
   wire [2:0] lastBit = {1'b1, wls};
   wire selBuf = regAddr == `UBF_OFF_BUF;
   wire selIer = regAddr == `UBF_OFF_IER;
   wire selIir = regAddr == `UBF_OFF_IIR;
   wire selLsr = regAddr == `UBF_OFF_LSR;
   wire wrThr = regWrite & selBuf & ~divisor_latch_access;
   wire wrDll = regWrite & selBuf & divisor_latch_access;
   wire wrDlm = regWrite & selIer & divisor_latch_access;
   wire wrIer = regWrite & selIer & ~divisor_latch_access;
   wire wrFcr = regWrite & selIir;
   wire rdRbr = regRead & selBuf & ~divisor_latch_access;
   wire rdLsr = regRead & selLsr;
   // Toggling FIFO mode flushes both queues, as in the classic part
   wire fifoModeChange = wrFcr & (regWrData[`UBF_FCR_FIFO_ENABLE_BIT] != fifoEnReg);
   wire rxFlush = wrFcr & (regWrData[`UBF_FCR_RXRST] | fifoModeChange);
   wire txFlush = wrFcr & (regWrData[`UBF_FCR_TXRST] | fifoModeChange);
   wire [4:0] depth = fifoEnReg ? `UBF_FIFO_DEPTH : 5'h01;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lcrReg <= `UBF_RESET_BYTE;
         ierReg <= `UBF_RESET_BYTE;
         mcrReg <= `UBF_RESET_BYTE;
         scrReg <= `UBF_RESET_BYTE;
         dllReg <= `UBF_RESET_DIV;
         dlmReg <= `UBF_RESET_DIV;
         fifoEnReg <= 1'b0;
         rxTrigReg <= 2'h0;
         tetReg <= 2'h0;
      end else begin
         if (regWrite && regAddr == `UBF_OFF_LCR) lcrReg <= regWrData;
         if (regWrite && regAddr == `UBF_OFF_MCR) mcrReg <= regWrData;
         if (regWrite && regAddr == `UBF_OFF_SCR) scrReg <= regWrData;
         if (wrDll) dllReg <= regWrData;
         if (wrDlm) dlmReg <= regWrData;
         if (wrIer) ierReg <= regWrData & 8'h87;
         if (wrFcr) begin
            fifoEnReg <= regWrData[`UBF_FCR_FIFO_ENABLE_BIT];
            tetReg <= regWrData[5:4];
            rxTrigReg <= regWrData[7:6];
         end
      end
   end

   // Sixteen ticks per bit; a zero divisor holds the generator still
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         baudCntReg <= 16'h0000;
         tickReg <= 1'b0;
      end else if (!baudRun) begin
         baudCntReg <= 16'h0000;
         tickReg <= 1'b0;
      end else if (baudCntReg >= divisor - 16'h0001) begin
         baudCntReg <= 16'h0000;
         tickReg <= 1'b1;
      end else begin
         baudCntReg <= baudCntReg + 16'h0001;
         tickReg <= 1'b0;
      end
   end

   // Transmit queue
   logic [3:0] txWrPtrReg, txRdPtrReg;
   logic [4:0] txCountReg;
   logic txPop;
   ubf_byte_t txHead;
   wire txPush = wrThr & (txCountReg < depth);
   wire [3:0] txRdAddr = txFlush ? 4'h0 : txRdPtrReg + {3'h0, txPop};
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         txWrPtrReg <= 4'h0;
         txRdPtrReg <= 4'h0;
         txCountReg <= 5'h00;
      end else if (txFlush) begin
         txWrPtrReg <= 4'h0;
         txRdPtrReg <= 4'h0;
         txCountReg <= 5'h00;
      end else begin
         txWrPtrReg <= txWrPtrReg + {3'h0, txPush};
         txRdPtrReg <= txRdAddr;
         txCountReg <= txCountReg + {4'h0, txPush} - {4'h0, txPop};
      end
   end
   ubf_fifo_mem #(.WIDTH(8), .DEPTH(16)) txMem (
      .clk_sys(clk_sys),
      .wrEn(txPush),
      .wrAddr(txWrPtrReg),
      .wrData(regWrData),
      .rdAddr(txRdAddr),
      .rdData(txHead)
   );

   // Transmitter
   ubf_state_t txStateReg;
   logic [5:0] txTickReg;
   logic [2:0] txBitReg;
   ubf_byte_t txShiftReg;
   logic txLineReg;
   wire txParity = lcrReg[`UBF_LCR_STICK] ? ~lcrReg[`UBF_LCR_EPS] :
                   (parityOf(txShiftReg, wls) ^ ~lcrReg[`UBF_LCR_EPS]);
   wire [5:0] stopLen = !lcrReg[2] ? `UBF_STOP_ONE : (wls == 2'h0 ? `UBF_STOP_HALF : `UBF_STOP_TWO);
   wire txBitEnd = tickReg & (txTickReg == `UBF_BIT_LAST);
   assign txPop = (txStateReg == UBF_IDLE) & tickReg & (txCountReg != 5'h00) & ~txFlush;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         txStateReg <= UBF_IDLE;
         txTickReg <= 6'h00;
         txBitReg <= 3'h0;
         txShiftReg <= `UBF_RESET_BYTE;
         txLineReg <= 1'b1;
      end else begin
         if (tickReg) txTickReg <= txTickReg + 6'h01;
         case (txStateReg)
            UBF_IDLE: begin
               txLineReg <= 1'b1;
               if (txPop) begin
                  txShiftReg <= txHead;
                  txTickReg <= 6'h00;
                  txLineReg <= 1'b0;
                  txStateReg <= UBF_START;
               end
            end
            UBF_START: if (txBitEnd) begin
               txTickReg <= 6'h00;
               txBitReg <= 3'h0;
               txLineReg <= txShiftReg[0];
               txStateReg <= UBF_DATA;
            end
            UBF_DATA: if (txBitEnd) begin
               txTickReg <= 6'h00;
               txBitReg <= txBitReg + 3'h1;
               if (txBitReg == lastBit) begin
                  txLineReg <= lcrReg[`UBF_LCR_PEN] ? txParity : 1'b1;
                  txStateReg <= lcrReg[`UBF_LCR_PEN] ? UBF_PARITY : UBF_STOP;
               end else begin
                  txLineReg <= txShiftReg[txBitReg + 3'h1];
               end
            end
            UBF_PARITY: if (txBitEnd) begin
               txTickReg <= 6'h00;
               txLineReg <= 1'b1;
               txStateReg <= UBF_STOP;
            end
            UBF_STOP: if (tickReg && txTickReg == stopLen - 6'h01) begin
               txStateReg <= UBF_IDLE;
            end
            default: txStateReg <= UBF_IDLE;
         endcase
      end
   end

   // Receive queue
   logic [3:0] rxWrPtrReg, rxRdPtrReg;
   logic [4:0] rxCountReg;
   logic rxPushReq;
   ubf_byte_t rxData, rxHead;
   wire rxPush = rxPushReq & (rxCountReg < depth) & ~rxFlush;
   wire rxOverrun = rxPushReq & (rxCountReg >= depth);
   wire rxPop = rdRbr & (rxCountReg != 5'h00) & ~rxFlush;
   wire [3:0] rxRdAddr = rxFlush ? 4'h0 : rxRdPtrReg + {3'h0, rxPop};
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxWrPtrReg <= 4'h0;
         rxRdPtrReg <= 4'h0;
         rxCountReg <= 5'h00;
      end else if (rxFlush) begin
         rxWrPtrReg <= 4'h0;
         rxRdPtrReg <= 4'h0;
         rxCountReg <= 5'h00;
      end else begin
         rxWrPtrReg <= rxWrPtrReg + {3'h0, rxPush};
         rxRdPtrReg <= rxRdAddr;
         rxCountReg <= rxCountReg + {4'h0, rxPush} - {4'h0, rxPop};
      end
   end
   ubf_fifo_mem #(.WIDTH(8), .DEPTH(16)) rxMem (
      .clk_sys(clk_sys),
      .wrEn(rxPush),
      .wrAddr(rxWrPtrReg),
      .wrData(rxData),
      .rdAddr(rxRdAddr),
      .rdData(rxHead)
   );

   // Receiver: confirm start at mid-bit, then sample every sixteen ticks
   ubf_state_t rxStateReg;
   logic [5:0] rxTickReg;
   logic [2:0] rxBitReg;
   ubf_byte_t rxShiftReg;
   logic rxParErrReg;
   wire rxSample = tickReg & (rxTickReg == `UBF_BIT_LAST);
   assign rxData = rxShiftReg >> (2'h3 - wls);
   wire rxExpPar = lcrReg[`UBF_LCR_STICK] ? ~lcrReg[`UBF_LCR_EPS] :
                   (parityOf(rxData, wls) ^ ~lcrReg[`UBF_LCR_EPS]);
   wire rxFrameErr = rxSample & (rxStateReg == UBF_STOP) & ~serialRxPin;
   assign rxPushReq = rxSample & (rxStateReg == UBF_STOP);
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxStateReg <= UBF_IDLE;
         rxTickReg <= 6'h00;
         rxBitReg <= 3'h0;
         rxShiftReg <= `UBF_RESET_BYTE;
         rxParErrReg <= 1'b0;
      end else if (tickReg) begin
         rxTickReg <= rxTickReg + 6'h01;
         case (rxStateReg)
            UBF_IDLE: begin
               rxTickReg <= 6'h00;
               rxParErrReg <= 1'b0;
               if (!serialRxPin) rxStateReg <= UBF_START;
            end
            UBF_START: if (rxTickReg == `UBF_MID_SAMPLE) begin
               rxTickReg <= 6'h00;
               rxBitReg <= 3'h0;
               rxStateReg <= serialRxPin ? UBF_IDLE : UBF_DATA;
            end
            UBF_DATA: if (rxSample) begin
               rxTickReg <= 6'h00;
               rxShiftReg <= {serialRxPin, rxShiftReg[7:1]};
               rxBitReg <= rxBitReg + 3'h1;
               if (rxBitReg == lastBit) begin
                  rxStateReg <= lcrReg[`UBF_LCR_PEN] ? UBF_PARITY : UBF_STOP;
               end
            end
            UBF_PARITY: if (rxSample) begin
               rxTickReg <= 6'h00;
               rxParErrReg <= serialRxPin != rxExpPar;
               rxStateReg <= UBF_STOP;
            end
            UBF_STOP: if (rxSample) begin
               rxStateReg <= UBF_IDLE;
            end
            default: rxStateReg <= UBF_IDLE;
         endcase
      end
   end

   // Sticky line errors; a new error in the reading cycle survives
   logic oeReg, peReg, feReg, biReg;
   wire breakSeen = rxFrameErr & (rxData == 8'h00) & ~serialRxPin;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         oeReg <= 1'b0;
         peReg <= 1'b0;
         feReg <= 1'b0;
         biReg <= 1'b0;
      end else begin
         oeReg <= rxOverrun | (oeReg & ~rdLsr);
         peReg <= (rxPushReq & rxParErrReg) | (peReg & ~rdLsr);
         feReg <= rxFrameErr | (feReg & ~rdLsr);
         biReg <= breakSeen | (biReg & ~rdLsr);
      end
   end

   // Character timeout: about four frames of silence with data waiting
   logic [9:0] toCntReg;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         toCntReg <= 10'h000;
      end else if (rxPush || rxPop || rxCountReg == 5'h00 || !fifoEnReg) begin
         toCntReg <= 10'h000;
      end else if (tickReg && toCntReg != `UBF_TIMEOUT_TICKS) begin
         toCntReg <= toCntReg + 10'h001;
      end
   end

   // Interrupt priority: line error, data, timeout, transmit
   wire lineErr = oeReg | peReg | feReg | biReg;
   wire ptimeMode = ierReg[`UBF_IER_PROG_TX_THRESHOLD_IRQ_EN] & fifoEnReg;
   wire threCond = ptimeMode ? (txCountReg <= txThreshold(tetReg)) : (txCountReg == 5'h00);
   wire srcLine = ierReg[`UBF_IER_LINE] & lineErr;
   wire srcData = ierReg[`UBF_IER_RXDATA] & (fifoEnReg ? rxCountReg >= rxTrigLevel(rxTrigReg) : rxCountReg != 5'h00);
   wire srcTimeout = ierReg[`UBF_IER_RXDATA] & fifoEnReg & (toCntReg == `UBF_TIMEOUT_TICKS);
   wire srcThre = ierReg[`UBF_IER_TX_HOLDING_EMPTY] & threCond;
   wire [3:0] iid = srcLine ? `UBF_IID_LINE : srcData ? `UBF_IID_RXDATA :
                    srcTimeout ? `UBF_IID_TIMEOUT : srcThre ? `UBF_IID_TX_HOLDING_EMPTY : `UBF_IID_NONE;
   wire txEmpty = (txStateReg == UBF_IDLE) & (txCountReg == 5'h00);
   wire [7:0] lsrVal = {lineErr, txEmpty, txCountReg == 5'h00, biReg, feReg, peReg, oeReg, rxCountReg != 5'h00};

   // Register read selection, as the classic map with DIVISOR_LATCH_ACCESS overlay
   wire [7:0] rdMux = selBuf ? (divisor_latch_access ? dllReg : rxHead) :
                      selIer ? (divisor_latch_access ? dlmReg : ierReg) :
                      selIir ? {fifoEnReg, fifoEnReg, 2'h0, iid} :
                      (regAddr == `UBF_OFF_LCR) ? lcrReg :
                      (regAddr == `UBF_OFF_MCR) ? mcrReg :
                      selLsr ? lsrVal :
                      (regAddr == `UBF_OFF_SCR) ? scrReg : 8'h00;

   // No flow-control pins exist; modem status reads as zero
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         regRdData <= `UBF_RESET_BYTE;
         serialTxPin <= 1'b1;
         irqOut <= 1'b0;
      end else begin
         if (regRead) regRdData <= rdMux;
         serialTxPin <= txLineReg & ~lcrReg[`UBF_LCR_BREAK];
         irqOut <= iid != `UBF_IID_NONE;
      end
   end
endmodule

// ---- ubf_uart_assertions.sv ----
// Concurrent checks on the serial port's register port and pins
`timescale 1ns/1ps
module ubf_uart_assertions (
   input wire logic clk_sys,
   input wire logic reset,
   input wire ubf_pkg::ubf_addr_t regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire ubf_pkg::ubf_byte_t regWrData,
   input wire ubf_pkg::ubf_byte_t regRdData,
   input wire logic serialRxPin,
   input wire logic serialTxPin,
   input wire logic irqOut
);
   import ubf_pkg::*;
   // Shadow copies of what software wrote, rebuilt from the strobes
   ubf_byte_t lcrSh, ierSh, scrSh, dllSh, dlmSh;
   logic fifoSh, everDiv;
   logic [19:0] lowRun;
   wire logic divisor_latch_access = lcrSh[7];
   wire logic [15:0] divSh = {dlmSh, dllSh};
   wire logic [19:0] bitLen = {divSh, 4'h0};
   wire logic [2:0] ierSrc = ierSh[2:0];
   wire ubf_byte_t divByte = regAddr[0] ? dlmSh : dllSh;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         {lcrSh, ierSh, scrSh, dllSh, dlmSh, fifoSh, everDiv} <= '0;
      end else if (regWrite) begin
         if (regAddr == 3'h0 && divisor_latch_access) dllSh <= regWrData;
         if (regAddr == 3'h1) begin
            if (divisor_latch_access) dlmSh <= regWrData;
            else ierSh <= regWrData & 8'h87;
         end
         if (regAddr == 3'h2) fifoSh <= regWrData[0];
         if (regAddr == 3'h3) lcrSh <= regWrData;
         if (regAddr == 3'h7) scrSh <= regWrData;
      end else begin
         everDiv <= everDiv | (divSh != 16'h0000);
      end
   end
   // Length of the current low stretch on the transmit pin
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) lowRun <= '0;
      else lowRun <= serialTxPin ? 20'h00000 : lowRun + 20'h00001;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_reset_quiet: assert property (disable iff (1'b0) reset |-> serialTxPin && !irqOut && regRdData == 8'h00)
      else $error("outputs not quiet in reset");
   a_silent_no_div: assert property (!everDiv && divSh == 16'h0000 |-> serialTxPin)
      else $error("transmit active with zero divisor");
   a_rd_holds: assert property (!regRead |=> $stable(regRdData))
      else $error("read data moved without a read");
   a_scr_readback: assert property (regRead && regAddr == 3'h7 |=> regRdData == $past(scrSh))
      else $error("scratch readback wrong");
   a_lcr_readback: assert property (regRead && regAddr == 3'h3 |=> regRdData == $past(lcrSh))
      else $error("line control readback wrong");
   a_div_readback: assert property (regRead && divisor_latch_access && regAddr[2:1] == 2'b00 |=> regRdData == $past(divByte))
      else $error("divisor byte readback wrong");
   a_ier_readback: assert property (regRead && !divisor_latch_access && regAddr == 3'h1 |=> regRdData == $past(ierSh))
      else $error("enable readback wrong");
   a_iir_fifo_bits: assert property (regRead && regAddr == 3'h2 |=> regRdData[7:4] == {$past(fifoSh), $past(fifoSh), 2'b00})
      else $error("identification upper bits wrong");
   a_no_timeout_off: assert property (regRead && regAddr == 3'h2 && !fifoSh |=> regRdData[3:0] != 4'hC)
      else $error("timeout reported outside FIFO mode");
   a_irq_needs_enable: assert property (ierSrc == 3'h0 && $past(ierSrc) == 3'h0 |-> !irqOut)
      else $error("interrupt with no source enabled");
   a_tx_bit_length: assert property ($rose(serialTxPin) && divSh != 16'h0000 |-> (lowRun % bitLen) == 20'h00000)
      else $error("low stretch not whole bit periods");
endmodule
bind ubf_uart ubf_uart_assertions uChk (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
   .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData), .serialRxPin(serialRxPin),
   .serialTxPin(serialTxPin), .irqOut(irqOut));

// ---- ubf_terminal.sv ----
// Remote serial terminal: frames bytes onto the port's receive line, decodes its transmit line
`timescale 1ns/1ps
module ubf_terminal #(
   parameter int BIT_NS = 640
) (
   input wire logic txLine,
   output logic rxLine,
   input wire logic [3:0] dataBits,
   input wire logic parEn,
   input wire logic parEven
);
   logic [9:0] gotQ[$];
   initial begin
      rxLine = 1'b1;
   end
   task automatic send(input logic [7:0] d, input logic badPar, input logic badStop);
      logic p;
      p = ^(d & ~(8'hFF << dataBits)) ^ !parEven ^ badPar;
      rxLine = 1'b0;
      #BIT_NS;
      for (int i = 0; i < int'(dataBits); i++) begin
         rxLine = d[i];
         #BIT_NS;
      end
      if (parEn) begin
         rxLine = p;
         #BIT_NS;
      end
      // A bad stop goes high again before the bit ends, so no false start follows
      rxLine = ~badStop;
      #(BIT_NS * 3 / 4);
      rxLine = 1'b1;
      #(BIT_NS / 4);
   endtask
   always begin
      logic [7:0] d;
      logic okPar;
      @(negedge txLine);
      d = 8'h00;
      okPar = 1'b1;
      #(BIT_NS / 2);
      for (int i = 0; i < int'(dataBits); i++) begin
         #BIT_NS;
         d[i] = txLine;
      end
      if (parEn) begin
         #BIT_NS;
         okPar = (txLine === (^d ^ !parEven));
      end
      #BIT_NS;
      gotQ.push_back({okPar, txLine === 1'b1, d});
      #(BIT_NS / 4);
   end
endmodule

// ---- tb.sv ----
// Self-checking bench for the serial port against a remote terminal model
`timescale 1ns/1ps
module tb;
   import ubf_pkg::*;
   logic clk_sys, reset, regWrite, regRead, serialRxPin, serialTxPin, irqOut, parEn, parEven;
   ubf_addr_t regAddr;
   ubf_byte_t regWrData, regRdData;
   logic [3:0] dataBits;
   int err_count = 0;
   int cmp_count = 0;
   ubf_uart uut (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWrData(regWrData), .regRdData(regRdData), .serialRxPin(serialRxPin), .serialTxPin(serialTxPin),
      .irqOut(irqOut));
   // Divisor 2 gives 32 clocks per bit
   ubf_terminal #(.BIT_NS(640)) uPeer (.txLine(serialTxPin), .rxLine(serialRxPin), .dataBits(dataBits),
      .parEn(parEn), .parEven(parEven));
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #2;
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(posedge clk_sys);
      #2;
      regWrite = 1'b0;
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string n);
      @(posedge clk_sys);
      #2;
      regAddr = a;
      regRead = 1'b1;
      @(posedge clk_sys);
      #2;
      regRead = 1'b0;
      chk(n, regRdData, e);
   endtask
   task automatic tx(input logic [7:0] d, input logic bp, input logic bs);
      @(posedge clk_sys);
      #2;
      uPeer.send(d, bp, bs);
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic waitTx(input int n);
      for (int i = 0; i < 20000 && uPeer.gotQ.size() < n; i++) @(posedge clk_sys);
   endtask
   task automatic popTx(input logic [7:0] e, input string n);
      logic [9:0] g;
      g = uPeer.gotQ.size() > 0 ? uPeer.gotQ.pop_front() : 10'h000;
      chk(n, g[7:0], e);
      chk(n, {6'h00, g[9:8]}, 8'h03);
   endtask
   task automatic t_reset();
      chk("txIdle", {7'h00, serialTxPin}, 8'h01);
      rdc(3'h2, 8'h01, "iirReset");
      rdc(3'h3, 8'h00, "lcrReset");
      rdc(3'h5, 8'h60, "lsrReset");
      wr(3'h0, 8'hA5);
      repeat (300) @(posedge clk_sys);
      chk("noFrame", 8'(uPeer.gotQ.size()), 8'h00);
   endtask
   task automatic t_divisor();
      wr(3'h3, 8'h83);
      wr(3'h1, 8'h01);
      rdc(3'h1, 8'h01, "divHigh");
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h02);
      rdc(3'h0, 8'h02, "divLow");
      wr(3'h3, 8'h03);
      rdc(3'h1, 8'h00, "ierBack");
      waitTx(1);
      popTx(8'hA5, "queuedChar");
   endtask
   task automatic t_formats();
      logic [7:0] lcrTab [7];
      logic [7:0] m;
      lcrTab = '{8'h03, 8'h1B, 8'h0B, 8'h02, 8'h01, 8'h00, 8'h07};
      foreach (lcrTab[i]) begin
         wr(3'h3, lcrTab[i]);
         dataBits = 4'h5 + {2'b00, lcrTab[i][1:0]};
         parEn = lcrTab[i][3];
         parEven = lcrTab[i][4];
         m = 8'hFF >> (2'h3 - lcrTab[i][1:0]);
         wr(3'h0, 8'hC6 ^ 8'(i));
         waitTx(1);
         popTx((8'hC6 ^ 8'(i)) & m, "txFormat");
         tx(8'h39 ^ 8'(i), 1'b0, 1'b0);
         rdc(3'h0, (8'h39 ^ 8'(i)) & m, "rxFormat");
         rdc(3'h5, 8'h60, "lsrClean");
      end
   endtask
   task automatic t_errors();
      wr(3'h3, 8'h1B);
      {dataBits, parEn, parEven} = {4'h8, 1'b1, 1'b1};
      wr(3'h1, 8'h04);
      tx(8'h5A, 1'b1, 1'b0);
      chk("irqLine", {7'h00, irqOut}, 8'h01);
      rdc(3'h2, 8'h06, "iirLine");
      rdc(3'h5, 8'hE5, "lsrParity");
      rdc(3'h5, 8'h61, "lsrCleared");
      rdc(3'h0, 8'h5A, "rxParity");
      repeat (2) @(posedge clk_sys);
      chk("irqDrop", {7'h00, irqOut}, 8'h00);
      tx(8'h5A, 1'b0, 1'b1);
      rdc(3'h5, 8'hE9, "lsrFrame");
      rdc(3'h0, 8'h5A, "rxFrame");
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h03);
      parEn = 1'b0;
   endtask
   task automatic t_fifo();
      // Trigger of four keeps two bytes below level, so only the timeout can fire
      wr(3'h2, 8'h41);
      rdc(3'h2, 8'hC1, "iirFifoOn");
      wr(3'h1, 8'h01);
      for (int i = 0; i < 2; i++) tx(8'(i), 1'b0, 1'b0);
      repeat (1000) @(posedge clk_sys);
      rdc(3'h2, 8'hC1, "noEarlyTimeout");
      repeat (400) @(posedge clk_sys);
      chk("irqTimeout", {7'h00, irqOut}, 8'h01);
      rdc(3'h2, 8'hCC, "iirTimeout");
      for (int i = 2; i < 17; i++) tx(8'(i), 1'b0, 1'b0);
      rdc(3'h5, 8'hE3, "lsrOverrun");
      rdc(3'h2, 8'hC4, "iirRxData");
      for (int i = 0; i < 16; i++) rdc(3'h0, 8'(i), "fifoData");
      rdc(3'h2, 8'hC1, "iirDrained");
      wr(3'h1, 8'h00);
   endtask
   task automatic t_threshold();
      wr(3'h2, 8'h21);
      wr(3'h1, 8'h82);
      for (int i = 0; i < 8; i++) wr(3'h0, 8'h80 + 8'(i));
      repeat (2) @(posedge clk_sys);
      chk("thrAbove", {7'h00, irqOut}, 8'h00);
      for (int i = 0; i < 20000 && irqOut !== 1'b1; i++) @(posedge clk_sys);
      chk("thrNotEmpty", 8'(uPeer.gotQ.size() < 5), 8'h01);
      rdc(3'h2, 8'hC2, "iirThre");
      wr(3'h1, 8'h02);
      repeat (2) @(posedge clk_sys);
      chk("threPlain", {7'h00, irqOut}, 8'h00);
      waitTx(8);
      chk("threEmpty", {7'h00, irqOut}, 8'h01);
      for (int i = 0; i < 8; i++) popTx(8'h80 + 8'(i), "thrData");
      wr(3'h1, 8'h00);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #1_000_000;
      err_count++;
      finish_test();
   end
   initial begin
      {reset, regWrite, regRead, parEn, parEven} = 5'b10000;
      {regAddr, regWrData, dataBits} = {3'h0, 8'h00, 4'h8};
      repeat (6) @(posedge clk_sys);
      #2;
      reset = 1'b0;
      t_reset();
      t_divisor();
      t_formats();
      t_errors();
      t_fifo();
      t_threshold();
      finish_test();
   end
endmodule
